// ---- logic/sxs_pkg.sv ----
package sxs_pkg;
    // ****************************************************************
    // bus and data widths
    // ****************************************************************
    localparam int ADDR_W = 32;
    localparam int DATA_W = 16;
    localparam int IRQ_W = 6;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 32'hFFFF_FF80;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 32'hFFFF_FF84;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 32'hFFFF_FF88;
    localparam logic [ADDR_W-1:0] OFF_EXC_CTRL = 32'hFFFF_FFE0;
    localparam logic [ADDR_W-1:0] OFF_RESET_CAUSE = 32'hFFFF_FFE4;
    localparam logic [ADDR_W-1:0] OFF_ABORT_CAUSE = 32'h0FFF_FFE8;
    localparam logic [ADDR_W-1:0] OFF_GLOBAL_SRC = 32'hFFFF_FFEC;
    localparam logic [ADDR_W-1:0] OFF_DEVICE_ID = 32'h0FFF_FFF0;
    localparam logic [ADDR_W-1:0] OFF_SOFT_FLAG = 32'h0FFF_FFF8;
    localparam logic [ADDR_W-1:0] OFF_SOFT_REQ = 32'h0FFF_FFFC;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int BIT_MAP_OVERLAP = 8;
    localparam int BIT_SW_RESET = 7;
    localparam int BIT_ADDR_ABORT = 15;
    localparam int BIT_MEM_ABORT = 14;
    localparam int BIT_PERIPH_VIOL = 13;
    localparam int BIT_SYS_ADDR = 7;
    localparam int BIT_SYS_ACC = 6;
    localparam int BIT_SOFT_FLAG = 0;
    localparam int RST_FIELD_HI = 15;
    localparam int RST_FIELD_LO = 14;
    localparam int KEY_HI = 15;
    localparam int KEY_LO = 8;
    localparam int MSG_HI = 7;
    localparam int MSG_LO = 0;

    // interrupt status bit positions
    localparam int IRQ_MAP = 0;
    localparam int IRQ_SOFTWARE_RESET_CAUSE_FLAG = 1;
    localparam int IRQ_ADDR = 2;
    localparam int IRQ_MEM = 3;
    localparam int IRQ_PERIPH = 4;
    localparam int IRQ_SOFT = 5;

    // ****************************************************************
    // values
    // ****************************************************************
    localparam logic [1:0] RST_FIELD_IDLE = 2'h1;
    localparam logic [7:0] SOFT_KEY = 8'h75;
    localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [IRQ_W-1:0] ZERO_IRQ = 6'h00;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } sxs_bus_s;

    typedef struct packed {
        logic user_mode;
        logic map_overlap;
        logic overlap_access;
        logic illegal_addr;
        logic prot_violation;
        logic periph_violation;
        logic sys_illegal_addr;
        logic sys_illegal_access;
    } sxs_evt_s;
endpackage

// ---- logic/sxs_exception_unit.sv ----
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
// Notes on behaviour
// - overlapping memory bases set the map-overlap flag; touching the overlap resets.
// - a software reset request sets the software-reset cause flag.
// - cause flags clear on a written 0; a written 1 leaves them alone.
// - user-mode illegal address aborts and sets the address-abort flag.
// - user-mode unpermitted protected access aborts and sets the memory-abort flag.
// - user-mode peripheral rule violation aborts and sets the peripheral flag.
// - global source bits survive warm resets; only power-on or software clears.
// - system-detected illegal address sets the system address source bit.
// - system-detected illegal access sets the system access source bit.
// - a fixed 16-bit identification register; writes ignored.
// - correct key write sets the soft flag until software writes 0.
// - key 0x75 raises a software interrupt request in any mode.
// - the key field is write-only and reads as zero.
// - an 8-bit read/write message field passes data to the handler.
// - reset field reads 01; any other written value forces a global reset.
// - cause flags are zero at power-up and kept through warm resets.
module sxs_exception_unit #(
    parameter logic [15:0] IDENT_CODE = 16'hA5C3 // arbitrary value
) (
    // clock and power-on reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // register port
    input wire sxs_pkg::sxs_bus_s i_bus,
    output logic [sxs_pkg::DATA_W-1:0] o_rdata,
    // system events
    input wire sxs_pkg::sxs_evt_s i_evt,
    // outputs to the system
    output logic o_sys_reset,
    output logic o_abort,
    output logic o_soft_irq,
    output logic o_irq
);
    import sxs_pkg::*;

    // ****************************************************************
    // decode
    // ****************************************************************
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction

    // clears bits written as 0, but a same-cycle set wins
    function automatic logic [DATA_W-1:0] w0c(input logic [DATA_W-1:0] cur,
                                               input logic wr,
                                               input logic [DATA_W-1:0] wd,
                                               input logic [DATA_W-1:0] set);
        return (wr ? (cur & wd) : cur) | set;
    endfunction

    wire logic wr_exc = i_bus.wr && hit(i_bus.addr, OFF_EXC_CTRL);
    wire logic wr_rcause = i_bus.wr && hit(i_bus.addr, OFF_RESET_CAUSE);
    wire logic wr_acause = i_bus.wr && hit(i_bus.addr, OFF_ABORT_CAUSE);
    wire logic wr_glb = i_bus.wr && hit(i_bus.addr, OFF_GLOBAL_SRC);
    wire logic wr_sflag = i_bus.wr && hit(i_bus.addr, OFF_SOFT_FLAG);
    wire logic wr_sreq = i_bus.wr && hit(i_bus.addr, OFF_SOFT_REQ);
    wire logic wr_ien = i_bus.wr && hit(i_bus.addr, OFF_IRQ_ENABLE);
    wire logic wr_iclr = i_bus.wr && hit(i_bus.addr, OFF_IRQ_CLEAR);

    // ****************************************************************
    // event qualification
    // ****************************************************************
    wire logic [1:0] rst_field = i_bus.wdata[RST_FIELD_HI:RST_FIELD_LO];
    wire logic sw_reset_req = wr_exc && (rst_field != RST_FIELD_IDLE);
    wire logic overlap_reset = i_evt.map_overlap && i_evt.overlap_access;
    wire logic addr_abort = i_evt.user_mode && i_evt.illegal_addr;
    wire logic mem_abort = i_evt.user_mode && i_evt.prot_violation;
    wire logic periph_abort = i_evt.user_mode && i_evt.periph_violation;
    wire logic key_ok = wr_sreq && (i_bus.wdata[KEY_HI:KEY_LO] == SOFT_KEY);

    // ****************************************************************
    // cause registers
    // ****************************************************************
    logic [DATA_W-1:0] rcause_reg;
    logic [DATA_W-1:0] acause_reg;
    logic [7:0] glb_reg;
    logic sflag_reg;
    logic [7:0] msg_reg;
    logic [IRQ_W-1:0] ista_reg;
    logic [IRQ_W-1:0] ien_reg;

    logic [DATA_W-1:0] rcause_set;
    logic [DATA_W-1:0] acause_set;
    logic [DATA_W-1:0] glb_set;

    always_comb begin
        rcause_set = ZERO_WORD;
        rcause_set[BIT_MAP_OVERLAP] = i_evt.map_overlap;
        rcause_set[BIT_SW_RESET] = sw_reset_req;
        acause_set = ZERO_WORD;
        acause_set[BIT_ADDR_ABORT] = addr_abort;
        acause_set[BIT_MEM_ABORT] = mem_abort;
        acause_set[BIT_PERIPH_VIOL] = periph_abort;
        glb_set = ZERO_WORD;
        glb_set[BIT_SYS_ADDR] = i_evt.sys_illegal_addr;
        glb_set[BIT_SYS_ACC] = i_evt.sys_illegal_access;
    end

    wire logic [DATA_W-1:0] rcause_mask = (16'h0001 << BIT_MAP_OVERLAP)
                                          | (16'h0001 << BIT_SW_RESET);
    wire logic [DATA_W-1:0] acause_mask = (16'h0001 << BIT_ADDR_ABORT)
                                          | (16'h0001 << BIT_MEM_ABORT)
                                          | (16'h0001 << BIT_PERIPH_VIOL);
    wire logic [DATA_W-1:0] glb_mask = (16'h0001 << BIT_SYS_ADDR) | (16'h0001 << BIT_SYS_ACC);

    wire logic [DATA_W-1:0] rcause_next =
        w0c(rcause_reg, wr_rcause, i_bus.wdata, rcause_set) & rcause_mask;
    wire logic [DATA_W-1:0] acause_next =
        w0c(acause_reg, wr_acause, i_bus.wdata, acause_set) & acause_mask;
    wire logic [DATA_W-1:0] glb_wide =
        w0c({ZERO_BYTE, glb_reg}, wr_glb, i_bus.wdata, glb_set) & glb_mask;
    wire logic sflag_next = (wr_sflag ? (sflag_reg & i_bus.wdata[BIT_SOFT_FLAG]) : sflag_reg)
                            | key_ok;
    wire logic [7:0] msg_next = wr_sreq ? i_bus.wdata[MSG_HI:MSG_LO] : msg_reg;

    // of the resets, only the power-on reset clears these; warm resets go out through o_sys_reset
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rcause_reg <= ZERO_WORD;
            acause_reg <= ZERO_WORD;
            glb_reg <= ZERO_BYTE;
            sflag_reg <= 1'b0;
            msg_reg <= ZERO_BYTE;
        end else begin
            rcause_reg <= rcause_next;
            acause_reg <= acause_next;
            glb_reg <= glb_wide[7:0];
            sflag_reg <= sflag_next;
            msg_reg <= msg_next;
        end
    end

    // ****************************************************************
    // interrupt status, enable and clear
    // ****************************************************************
    logic [IRQ_W-1:0] ievt;
    logic [IRQ_W-1:0] ista_next;

    always_comb begin
        ievt = ZERO_IRQ;
        ievt[IRQ_MAP] = i_evt.map_overlap;
        ievt[IRQ_SOFTWARE_RESET_CAUSE_FLAG] = sw_reset_req;
        ievt[IRQ_ADDR] = addr_abort;
        ievt[IRQ_MEM] = mem_abort;
        ievt[IRQ_PERIPH] = periph_abort;
        ievt[IRQ_SOFT] = key_ok;
    end

    // set wins over a write-one clear in the same cycle
    for (genvar g = 0; g < IRQ_W; g++) begin : g_ista
        assign ista_next[g] = ievt[g] | (ista_reg[g] & ~(wr_iclr & i_bus.wdata[g]));
    end

    wire logic [IRQ_W-1:0] ien_next = wr_ien ? i_bus.wdata[IRQ_W-1:0] : ien_reg;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ista_reg <= ZERO_IRQ;
            ien_reg <= ZERO_IRQ;
        end else begin
            ista_reg <= ista_next;
            ien_reg <= ien_next;
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    logic [DATA_W-1:0] rd_mux;

    always_comb begin
        rd_mux = ZERO_WORD;
        if (hit(i_bus.addr, OFF_EXC_CTRL)) begin
            rd_mux[RST_FIELD_HI:RST_FIELD_LO] = RST_FIELD_IDLE;
        end else if (hit(i_bus.addr, OFF_RESET_CAUSE)) begin
            rd_mux = rcause_reg;
        end else if (hit(i_bus.addr, OFF_ABORT_CAUSE)) begin
            rd_mux = acause_reg;
        end else if (hit(i_bus.addr, OFF_GLOBAL_SRC)) begin
            rd_mux[7:0] = glb_reg;
        end else if (hit(i_bus.addr, OFF_DEVICE_ID)) begin
            rd_mux = IDENT_CODE;
        end else if (hit(i_bus.addr, OFF_SOFT_FLAG)) begin
            rd_mux[BIT_SOFT_FLAG] = sflag_reg;
        end else if (hit(i_bus.addr, OFF_SOFT_REQ)) begin
            rd_mux[MSG_HI:MSG_LO] = msg_reg;
        end else if (hit(i_bus.addr, OFF_IRQ_STATUS)) begin
            rd_mux[IRQ_W-1:0] = ista_reg;
        end else if (hit(i_bus.addr, OFF_IRQ_ENABLE)) begin
            rd_mux[IRQ_W-1:0] = ien_reg;
        end
    end

    wire logic [DATA_W-1:0] rdata_next = i_bus.rd ? rd_mux : ZERO_WORD;

    // ****************************************************************
    // output flops
    // ****************************************************************
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= ZERO_WORD;
            o_sys_reset <= 1'b0;
            o_abort <= 1'b0;
            o_soft_irq <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            o_rdata <= rdata_next;
            o_sys_reset <= sw_reset_req | overlap_reset;
            o_abort <= addr_abort | mem_abort | periph_abort;
            o_soft_irq <= key_ok;
            o_irq <= |(ista_next & ien_next);
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    AST_MAP_FLAG: assert property (
        i_evt.map_overlap |=> rcause_reg[BIT_MAP_OVERLAP] && ista_reg[IRQ_MAP])
        else $error("map overlap flag not set");
    AST_MAP_RESET: assert property (
        (i_evt.map_overlap && i_evt.overlap_access) |=> o_sys_reset)
        else $error("overlap access gave no reset");
    AST_SW_RESET: assert property (
        (wr_exc && rst_field != RST_FIELD_IDLE) |=> o_sys_reset && rcause_reg[BIT_SW_RESET])
        else $error("software reset not raised or not recorded");
    AST_NO_RESET: assert property (
        (i_bus.wr && !overlap_reset && !sw_reset_req) |=> !o_sys_reset)
        else $error("reset without cause");
    AST_CLEAR_ZERO: assert property (
        (wr_rcause && !i_bus.wdata[BIT_SW_RESET] && !sw_reset_req)
        |=> !rcause_reg[BIT_SW_RESET])
        else $error("written zero did not clear");
    AST_KEEP_ONE: assert property (
        (wr_acause && i_bus.wdata[BIT_ADDR_ABORT] && acause_reg[BIT_ADDR_ABORT])
        |=> acause_reg[BIT_ADDR_ABORT])
        else $error("written one changed a flag");
    AST_ADDR_ABORT: assert property (
        (i_evt.user_mode && i_evt.illegal_addr) |=> o_abort && acause_reg[BIT_ADDR_ABORT])
        else $error("address abort missing");
    AST_MEM_ABORT: assert property (
        (i_evt.user_mode && i_evt.prot_violation) |=> o_abort && acause_reg[BIT_MEM_ABORT])
        else $error("memory abort missing");
    AST_PERIPH_ABORT: assert property (
        (i_evt.user_mode && i_evt.periph_violation)
        |=> o_abort && acause_reg[BIT_PERIPH_VIOL])
        else $error("peripheral abort missing");
    AST_GLB_HOLD: assert property (
        (!wr_glb && !i_evt.sys_illegal_addr && !i_evt.sys_illegal_access) |=> $stable(glb_reg))
        else $error("global source changed without cause");
    AST_SYS_ADDR: assert property (
        i_evt.sys_illegal_addr |=> glb_reg[BIT_SYS_ADDR])
        else $error("system address source not set");
    AST_SYS_ACC: assert property (
        i_evt.sys_illegal_access |=> glb_reg[BIT_SYS_ACC])
        else $error("system access source not set");
    AST_ID_READ: assert property (
        (i_bus.rd && hit(i_bus.addr, OFF_DEVICE_ID)) |=> o_rdata == IDENT_CODE)
        else $error("identification read wrong");
    AST_SOFT_FLAG: assert property (
        key_ok |=> sflag_reg ##1 (sflag_reg || $past(wr_sflag)))
        else $error("soft flag not held");
    AST_SOFT_PULSE: assert property (
        key_ok ##1 !key_ok |-> o_soft_irq ##1 !o_soft_irq)
        else $error("soft request not a single pulse");
    AST_KEY_ZERO: assert property (
        (i_bus.rd && hit(i_bus.addr, OFF_SOFT_REQ)) |=> o_rdata[KEY_HI:KEY_LO] == ZERO_BYTE)
        else $error("key field read nonzero");
    AST_MSG_KEEP: assert property (
        wr_sreq |=> msg_reg == $past(i_bus.wdata[MSG_HI:MSG_LO]))
        else $error("message not stored");
    AST_RST_FIELD: assert property (
        (i_bus.rd && hit(i_bus.addr, OFF_EXC_CTRL))
        |=> o_rdata[RST_FIELD_HI:RST_FIELD_LO] == RST_FIELD_IDLE)
        else $error("reset field not read as idle");
    AST_IRQ_LEVEL: assert property (
        o_irq == |(ista_reg & ien_reg))
        else $error("interrupt level wrong");

    // ****************************************************************
    // assertions on holding, clearing, setting, reads and quiet outputs
    // ****************************************************************
    AST_ACAUSE_HOLD: assert property (
        (!wr_acause && !addr_abort && !mem_abort && !periph_abort) |=> $stable(acause_reg))
        else $error("abort cause changed without cause");
    AST_RCAUSE_HOLD: assert property (
        (!wr_rcause && !i_evt.map_overlap && !sw_reset_req) |=> $stable(rcause_reg))
        else $error("reset cause changed without cause");
    AST_SOFTWARE_RESET_CAUSE_FLAG_KEEP: assert property (
        (rcause_reg[BIT_SW_RESET] && !wr_rcause) |=> rcause_reg[BIT_SW_RESET])
        else $error("software reset flag lost");
    AST_GLB_KEEP: assert property (
        (glb_reg[BIT_SYS_ACC] && !wr_glb) |=> glb_reg[BIT_SYS_ACC])
        else $error("system access source lost");
    AST_SFLAG_HOLD: assert property (
        (sflag_reg && !wr_sflag) |=> sflag_reg)
        else $error("soft flag dropped without clear");
    AST_MSG_HOLD: assert property (
        !wr_sreq |=> $stable(msg_reg))
        else $error("message changed without write");
    AST_SFLAG_ONLY_KEY: assert property (
        (!sflag_reg && !wr_sreq) |=> !sflag_reg)
        else $error("soft flag set without key");

    AST_MAP_CLEAR: assert property (
        (wr_rcause && !i_bus.wdata[BIT_MAP_OVERLAP] && !i_evt.map_overlap)
        |=> !rcause_reg[BIT_MAP_OVERLAP])
        else $error("map flag not cleared by zero");
    AST_MEM_CLEAR: assert property (
        (wr_acause && !i_bus.wdata[BIT_MEM_ABORT] && !mem_abort)
        |=> !acause_reg[BIT_MEM_ABORT])
        else $error("memory abort flag not cleared by zero");
    AST_GLB_CLEAR: assert property (
        (wr_glb && !i_bus.wdata[BIT_SYS_ADDR] && !i_evt.sys_illegal_addr)
        |=> !glb_reg[BIT_SYS_ADDR])
        else $error("system address source not cleared by zero");
    AST_SFLAG_CLEAR: assert property (
        (wr_sflag && !i_bus.wdata[BIT_SOFT_FLAG]) |=> !sflag_reg)
        else $error("soft flag not cleared by zero");
    AST_ISTA_CLEAR: assert property (
        (wr_iclr && i_bus.wdata[IRQ_SOFT]) |=> !ista_reg[IRQ_SOFT])
        else $error("interrupt status not cleared");
    AST_IEN_WRITE: assert property (
        wr_ien |=> ien_reg == $past(i_bus.wdata[IRQ_W-1:0]))
        else $error("interrupt enable not stored");

    AST_ABORT_NONE: assert property (
        (!i_evt.user_mode || !(i_evt.illegal_addr || i_evt.prot_violation
                               || i_evt.periph_violation)) |=> !o_abort)
        else $error("abort without user-mode cause");
    AST_RESET_NONE: assert property (
        (!wr_exc && !i_evt.overlap_access) |=> !o_sys_reset)
        else $error("reset without request or overlap access");
    AST_IDLE_FIELD: assert property (
        (wr_exc && i_bus.wdata[RST_FIELD_HI:RST_FIELD_LO] == RST_FIELD_IDLE && !overlap_reset)
        |=> !o_sys_reset)
        else $error("idle reset field caused a reset");
    AST_SOFT_IDLE: assert property (
        !wr_sreq |=> !o_soft_irq)
        else $error("soft request without key write");
    AST_SOFT_BADKEY: assert property (
        (wr_sreq && i_bus.wdata[KEY_HI:KEY_LO] != SOFT_KEY)
        |=> !o_soft_irq)
        else $error("soft request from a wrong key");
    AST_SOFT_KEY: assert property (
        (wr_sreq && i_bus.wdata[KEY_HI:KEY_LO] == SOFT_KEY)
        |=> o_soft_irq && sflag_reg && ista_reg[IRQ_SOFT])
        else $error("key write gave no soft request");
    AST_MEM_STATUS: assert property (
        (i_evt.user_mode && i_evt.prot_violation) |=> ista_reg[IRQ_MEM])
        else $error("memory abort status not set");

    AST_RDATA_IDLE: assert property (
        !i_bus.rd |=> o_rdata == ZERO_WORD)
        else $error("read data without read");
    AST_MSG_READ: assert property (
        (i_bus.rd && hit(i_bus.addr, OFF_SOFT_REQ))
        |=> o_rdata[MSG_HI:MSG_LO] == $past(msg_reg))
        else $error("message read wrong");
    AST_FLAG_READ: assert property (
        (i_bus.rd && hit(i_bus.addr, OFF_SOFT_FLAG))
        |=> o_rdata[BIT_SOFT_FLAG] == $past(sflag_reg))
        else $error("soft flag read wrong");

    COV_SOFT: cover property (key_ok ##1 o_soft_irq ##1 (wr_sflag && !i_bus.wdata[BIT_SOFT_FLAG]));
    COV_SW_RESET: cover property (sw_reset_req ##1 o_sys_reset);
    COV_ABORT_IRQ: cover property (addr_abort ##1 o_irq);
    COV_SET_CLEAR: cover property (wr_rcause && i_evt.map_overlap && !i_bus.wdata[BIT_MAP_OVERLAP]);
    COV_B2B_KEY: cover property (key_ok ##1 key_ok ##1 !key_ok);
endmodule

// ---- tb/sxs_exception_unit_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin $display("[ERR] %s expected %h seen %h", nm, exp, got); err_total++; end end

module sxs_exception_unit_tb_top;
    import sxs_pkg::*;

    // ****************************************************************
    // signals and instance
    // ****************************************************************
    localparam logic [15:0] ID_VAL = 16'h3C5A; // arbitrary value
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    sxs_bus_s bus_q = '0;
    sxs_evt_s evt_q = '0;
    logic [DATA_W-1:0] o_rdata;
    logic o_sys_reset;
    logic o_abort;
    logic o_soft_irq;
    logic o_irq;
    int err_total = 0;
    int n_checks = 0;
    logic [7:0] msg;
    logic [7:0] key;
    logic [DATA_W-1:0] ab_exp;

    always #5 i_clock = ~i_clock;

    sxs_exception_unit #(.IDENT_CODE(ID_VAL)) dut (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_bus(bus_q),
        .o_rdata(o_rdata),
        .i_evt(evt_q),
        .o_sys_reset(o_sys_reset),
        .o_abort(o_abort),
        .o_soft_irq(o_soft_irq),
        .o_irq(o_irq)
    );

    // ****************************************************************
    // expectations and bus cycles
    // ****************************************************************
    function automatic logic [15:0] req_view(input logic [7:0] m);
        return {8'h00, m};
    endfunction

    function automatic logic rst_req(input logic [1:0] f);
        return f != RST_FIELD_IDLE;
    endfunction

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_clock);
        bus_q <= '{a, d, 1'b1, 1'b0};
        @(posedge i_clock);
        bus_q <= '0;
        #1;
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string nm);
        @(posedge i_clock);
        bus_q <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge i_clock);
        bus_q <= '0;
        #1;
        `CHK(nm, e, o_rdata)
    endtask

    // one cycle of system events, then idle
    task automatic evt(input logic [7:0] v);
        @(posedge i_clock);
        evt_q <= v;
        @(posedge i_clock);
        evt_q <= '0;
        #1;
    endtask

    task automatic conclude();
        if (err_total == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge i_clock);
        err_total++;
        conclude();
    end

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        void'($urandom(32'ha328));
        repeat (20) @(posedge i_clock);
        i_rst_n <= 1'b1;
        rd_chk(OFF_ABORT_CAUSE, 16'h0000, "abort_rst");
        rd_chk(OFF_RESET_CAUSE, 16'h0000, "cause_rst");
        rd_chk(OFF_GLOBAL_SRC, 16'h0000, "global_rst");
        rd_chk(OFF_SOFT_FLAG, 16'h0000, "flag_rst");
        rd_chk(OFF_SOFT_REQ, 16'h0000, "req_rst");
        rd_chk(OFF_EXC_CTRL, 16'h4000, "ctrl_read");
        wr(OFF_DEVICE_ID, ~ID_VAL);
        rd_chk(OFF_DEVICE_ID, ID_VAL, "ident");
        wr(32'h1234_5670, 16'hFFFF);
        rd_chk(32'h1234_5670, 16'h0000, "unmapped");
        // aborts only count in user mode
        ab_exp = 16'h0000;
        for (int um = 0; um < 2; um++) begin
            for (int k = 0; k < 3; k++) begin
                evt({um[0], 7'h00} | (8'h10 >> k));
                `CHK("abort", um[0], o_abort)
                if (um == 1) begin
                    ab_exp = ab_exp | (16'h8000 >> k);
                end
                rd_chk(OFF_ABORT_CAUSE, ab_exp, "abort_reg");
            end
        end
        wr(OFF_ABORT_CAUSE, 16'h6000);
        rd_chk(OFF_ABORT_CAUSE, 16'h6000, "abort_w0c");
        wr(OFF_ABORT_CAUSE, 16'h0000);
        rd_chk(OFF_ABORT_CAUSE, 16'h0000, "abort_clr");
        evt(8'h02);
        evt(8'h01);
        rd_chk(OFF_GLOBAL_SRC, 16'h00C0, "global_set");
        // every reset field value, only 01 is harmless
        for (int f = 0; f < 4; f++) begin
            wr(OFF_EXC_CTRL, {f[1:0], 14'h3FFF});
            `CHK("sw_reset", rst_req(f[1:0]), o_sys_reset)
        end
        rd_chk(OFF_RESET_CAUSE, 16'h0080, "cause_sw");
        rd_chk(OFF_GLOBAL_SRC, 16'h00C0, "global_kept");
        evt(8'h40);
        `CHK("map_no_rst", 1'b0, o_sys_reset)
        evt(8'h60);
        `CHK("map_rst", 1'b1, o_sys_reset)
        rd_chk(OFF_RESET_CAUSE, 16'h0180, "cause_map");
        wr(OFF_RESET_CAUSE, 16'hFEFF);
        rd_chk(OFF_RESET_CAUSE, 16'h0080, "cause_w0c");
        wr(OFF_RESET_CAUSE, 16'h0000);
        rd_chk(OFF_RESET_CAUSE, 16'h0000, "cause_clr");
        wr(OFF_GLOBAL_SRC, 16'h0040);
        rd_chk(OFF_GLOBAL_SRC, 16'h0040, "global_w0c");
        // soft interrupt with correct and random keys in turn, and random messages
        rd_chk(OFF_IRQ_STATUS, 16'h001F, "irq_events");
        wr(OFF_IRQ_CLEAR, 16'h003F);
        rd_chk(OFF_IRQ_STATUS, 16'h0000, "irq_clr");
        wr(OFF_IRQ_ENABLE, 16'(1 << IRQ_SOFT));
        rd_chk(OFF_IRQ_ENABLE, 16'h0020, "irq_en");
        `CHK("irq_idle", 1'b0, o_irq)
        for (int i = 0; i < 12; i++) begin
            msg = 8'($urandom);
            key = (i % 2 == 1) ? 8'($urandom) : SOFT_KEY;
            wr(OFF_SOFT_REQ, {key, msg});
            `CHK("soft_irq", key === SOFT_KEY, o_soft_irq)
            rd_chk(OFF_SOFT_REQ, req_view(msg), "req_read");
        end
        rd_chk(OFF_SOFT_FLAG, 16'h0001, "flag_set");
        rd_chk(OFF_IRQ_STATUS, 16'h0020, "irq_status");
        `CHK("irq_on", 1'b1, o_irq)
        wr(OFF_IRQ_ENABLE, 16'h0000);
        rd_chk(OFF_IRQ_STATUS, 16'h0020, "irq_sticky");
        `CHK("irq_masked", 1'b0, o_irq)
        wr(OFF_SOFT_FLAG, 16'h0001);
        rd_chk(OFF_SOFT_FLAG, 16'h0001, "flag_w1");
        wr(OFF_SOFT_FLAG, 16'h0000);
        rd_chk(OFF_SOFT_FLAG, 16'h0000, "flag_w0");
        wr(OFF_IRQ_ENABLE, 16'h0020);
        rd_chk(OFF_IRQ_STATUS, 16'h0020, "irq_status2");
        `CHK("irq_unmask", 1'b1, o_irq)
        wr(OFF_IRQ_CLEAR, 16'h0020);
        rd_chk(OFF_IRQ_STATUS, 16'h0000, "irq_cleared");
        `CHK("irq_off", 1'b0, o_irq)
        // two key writes back to back hold o_soft_irq high for two cycles, then it drops
        @(posedge i_clock);
        bus_q <= '{OFF_SOFT_REQ, {SOFT_KEY, 8'h5A}, 1'b1, 1'b0};
        @(posedge i_clock);
        #1;
        `CHK("b2b_first", 1'b1, o_soft_irq)
        @(posedge i_clock);
        bus_q <= '0;
        #1;
        `CHK("b2b_second", 1'b1, o_soft_irq)
        @(posedge i_clock);
        #1;
        `CHK("b2b_end", 1'b0, o_soft_irq)
        conclude();
    end
endmodule
